// ---- rtl/sig_pkg.sv ----
// Purpose: shared constants for the signature / protect / power-up link
// Assumes: 25 MHz system clock on both ends
// Notes: opcode values and delay figures are plain defaults
package sig_pkg;
	// system clock period in ns
	localparam int CLK_NS = 40;
	// instruction opcodes (plain defaults)
	localparam logic [7:0] RELEASE_SIGNATURE_OP = 8'hAB;
	localparam logic [7:0] SOFT_PROTECT_OP = 8'hB9;
	localparam logic [7:0] DEEP_POWERDOWN_OP = 8'hB1;
	// signature value, arbitrary
	localparam logic [7:0] SIGNATURE_VAL = 8'h5A;
	// dummy bytes after the release opcode
	localparam int DUMMY_BYTES = 3;
	localparam logic [5:0] SIG_START_BIT = 6'h20;
	// delays, in their own units
	localparam int RELEASE_DELAY_NS = 3000;
	localparam int PROTECT_ENTRY_DELAY_NS = 3000;
	localparam int POWERUP_DELAY_US = 2000;
	// cycle counts: least times round up, longest round down
	localparam int RELEASE_CYC = RELEASE_DELAY_NS / CLK_NS;
	localparam int PROTECT_CYC = (PROTECT_ENTRY_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int POWERUP_CYC = (POWERUP_DELAY_US * 1000 + CLK_NS - 1) / CLK_NS;
	// host serial clock divider: half period in system cycles
	localparam logic [3:0] SCK_HALF = 4'h4;
	// device operating modes
	typedef enum logic [1:0] {
		MODE_STANDBY = 2'b00,
		MODE_PROTECT = 2'b01,
		MODE_RELEASING = 2'b10,
		MODE_ENTERING = 2'b11
	} mode_e;
	// host sequencer states
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_SHIFT = 2'b01,
		H_GAP = 2'b10
	} host_e;
endpackage

// ---- rtl/spi_link_if.sv ----
// Purpose: serial link between host and device
// Assumes: chip select and clock driven by host only
// Notes: so has an output enable, active low
`timescale 1ns/1ps
interface spi_link_if;
	logic chip_select_n; // select, active low
	logic sck; // serial clock
	logic si; // host to device data
	logic so_o; // device data out
	logic so_oe_n; // device drives so when low
	logic so; // resolved so level
	assign so = so_oe_n ? 1'b1 : so_o;
	modport host(output chip_select_n, output sck, output si, input so);
	modport dev(input chip_select_n, input sck, input si,
		output so_o, output so_oe_n);
endinterface

// ---- rtl/sig_device.sv ----
// Purpose: device end: release, signature, soft protect, power-up lockout
// Assumes: spi mode 0, host makes sck, busy_in from self-timed engine
// Notes: all link pins pass two flip-flops before use
//
// Functional notes
// - in protect mode only release opcode acts
// - release ignored while busy cycle runs
// - select low, opcode sampled on rising sck
// - early deselect after opcode still releases
// - standby entered only after release delay
// - host keeps select high for release delay
// - signature returned whether protected or not
// - three dummy bytes sampled and ignored
// - signature shifted out on falling sck
// - signature repeats while clocks continue
// - deselect after signature ends instruction
// - host waits power-up delay before selecting
// - power-on reset holds all logic
// - instructions ignored until power-up delay expires
// - reset leaves standby, write enable cleared
// - host waits power-up before write commands
// - protect acts only if deselect after exactly eight bits
// - deep power-down opcode same as protect
// - busy flag high while self-timed cycle runs
`timescale 1ns/1ps
module sig_device
	import sig_pkg::*;
(
	input wire logic clk_in,
	input wire logic rstn_in, // power-on reset, active low
	spi_link_if.dev link,
	input wire logic busy_in, // self-timed cycle running
	input wire logic wel_set_in, // write enable set pulse
	output logic busy_flag_out,
	output logic write_enable_latch_out,
	output logic soft_protect_mode_out,
	output logic ready_out // power-up delay done
);
	// synchronisers for the link pins
	logic [1:0] cs_s_q, sck_s_q, si_s_q;
	logic sck_prev_q, cs_prev_q;
	logic cs_n, sck, si, rise, fall, cs_rise;
	mode_e mode_q;
	logic [5:0] bitcnt_q; // bits taken this frame
	logic [7:0] opcode_q; // opcode shift
	logic is_release_q; // frame holds a release opcode
	logic drop_q; // frame is discarded
	logic [2:0] sig_idx_q; // signature bit index
	logic so_q, so_en_q;
	logic [16:0] delay_q; // release / entry counter
	logic [16:0] pu_q; // power-up counter
	logic pu_done;

	// two flip-flop capture of pins
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cs_s_q <= 2'h3;
			sck_s_q <= 2'h0;
			si_s_q <= 2'h0;
		end else begin
			cs_s_q <= {cs_s_q[0], link.chip_select_n};
			sck_s_q <= {sck_s_q[0], link.sck};
			si_s_q <= {si_s_q[0], link.si};
		end
	end
	assign cs_n = cs_s_q[1];
	assign sck = sck_s_q[1];
	assign si = si_s_q[1];

	// edge history
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sck_prev_q <= 1'b0;
			cs_prev_q <= 1'b1;
		end else begin
			sck_prev_q <= sck;
			cs_prev_q <= cs_n;
		end
	end
	assign rise = !cs_n && sck && !sck_prev_q;
	assign fall = !cs_n && !sck && sck_prev_q;
	assign cs_rise = cs_n && !cs_prev_q;

	// power-up lockout counter
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pu_q <= 17'(POWERUP_CYC);
		end else if (pu_q != 17'h0) begin
			pu_q <= pu_q - 17'h1;
		end
	end
	assign pu_done = (pu_q == 17'h0);
	assign ready_out = pu_done;

	// bit counter and opcode capture
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			bitcnt_q <= 6'h0;
			opcode_q <= 8'h0;
			drop_q <= 1'b0;
			is_release_q <= 1'b0;
		end else if (cs_n) begin
			bitcnt_q <= 6'h0;
			drop_q <= 1'b0;
			is_release_q <= 1'b0;
		end else if (rise) begin
			// frame starting too early or mid-delay is dropped
			if (bitcnt_q == 6'h0 && (!pu_done || mode_q[1])) begin
				drop_q <= 1'b1;
			end
			if (bitcnt_q < SIG_START_BIT) begin
				bitcnt_q <= bitcnt_q + 6'h1;
			end
			if (bitcnt_q < 6'h8) begin
				opcode_q <= {opcode_q[6:0], si};
			end
			if (bitcnt_q == 6'h7 && !drop_q && !busy_in &&
				{opcode_q[6:0], si} == RELEASE_SIGNATURE_OP) begin
				is_release_q <= 1'b1;
			end
		end
	end

	// signature shifter, launched on falling sck
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sig_idx_q <= 3'h7;
			so_q <= 1'b0;
			so_en_q <= 1'b0;
		end else if (cs_n) begin
			sig_idx_q <= 3'h7;
			so_en_q <= 1'b0;
		end else if (fall && is_release_q && bitcnt_q == SIG_START_BIT) begin
			so_en_q <= 1'b1;
			so_q <= SIGNATURE_VAL[sig_idx_q];
			sig_idx_q <= sig_idx_q - 3'h1; // wraps: repeat
		end
	end
	assign link.so_o = so_q;
	assign link.so_oe_n = !so_en_q;

	// mode machine with release and entry delays
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mode_q <= MODE_STANDBY;
			delay_q <= 17'h0;
		end else begin
			case (mode_q)
				MODE_STANDBY, MODE_PROTECT: begin
					if (cs_rise && is_release_q) begin
						// any deselect after opcode releases
						mode_q <= MODE_RELEASING;
						delay_q <= 17'(RELEASE_CYC);
					end else if (cs_rise && !drop_q && !busy_in &&
						mode_q == MODE_STANDBY && bitcnt_q == 6'h8 &&
						(opcode_q == SOFT_PROTECT_OP ||
						opcode_q == DEEP_POWERDOWN_OP)) begin
						mode_q <= MODE_ENTERING;
						delay_q <= 17'(PROTECT_CYC);
					end
					// other opcodes in protect mode fall away
				end
				MODE_RELEASING: begin
					if (delay_q == 17'h0) begin
						mode_q <= MODE_STANDBY;
					end else begin
						delay_q <= delay_q - 17'h1;
					end
				end
				MODE_ENTERING: begin
					if (delay_q == 17'h0) begin
						mode_q <= MODE_PROTECT;
					end else begin
						delay_q <= delay_q - 17'h1;
					end
				end
				default: begin
					mode_q <= MODE_STANDBY;
				end
			endcase
		end
	end
	assign soft_protect_mode_out = (mode_q == MODE_PROTECT);

	// write enable latch, cleared at reset and end of busy cycle
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			write_enable_latch_out <= 1'b0;
		end else if (wel_set_in && pu_done && mode_q == MODE_STANDBY) begin
			write_enable_latch_out <= 1'b1;
		end else if (busy_flag_out && !busy_in) begin
			write_enable_latch_out <= 1'b0;
		end
	end

	// busy flag mirrors the self-timed engine
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			busy_flag_out <= 1'b0;
		end else begin
			busy_flag_out <= busy_in;
		end
	end
endmodule

// ---- rtl/sig_host.sv ----
// Purpose: host end: sends release / protect frames, reads signature
// Assumes: spi mode 0, host makes sck by dividing clk_in
// Notes: waits power-up and release delays before selecting
`timescale 1ns/1ps
module sig_host
	import sig_pkg::*;
(
	input wire logic clk_in,
	input wire logic rstn_in,
	spi_link_if.host link,
	input wire logic start_in, // request pulse
	input wire logic [7:0] op_in, // opcode to send
	input wire logic [3:0] sig_reads_in, // signature bytes to read
	output logic busy_out,
	output logic done_out, // one-cycle pulse
	output logic [7:0] sig_out // last signature byte
);
	host_e st_q;
	logic [3:0] div_q;
	logic [7:0] nbits_q, total_q; // rises sent, rises wanted (up to 152)
	logic [7:0] tx_q, rx_q;
	logic [16:0] wait_q; // power-up then gap counter
	logic [1:0] so_s_q; // so synchroniser
	logic cs_q, sck_q, rel_q;

	// so capture
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			so_s_q <= 2'h0;
		end else begin
			so_s_q <= {so_s_q[0], link.so};
		end
	end

	// sequencer
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_q <= H_GAP;
			wait_q <= 17'(POWERUP_CYC);
			cs_q <= 1'b1;
			sck_q <= 1'b0;
			div_q <= 4'h0;
			nbits_q <= 8'h0;
			total_q <= 8'h0;
			tx_q <= 8'h0;
			rx_q <= 8'h0;
			sig_out <= 8'h0;
			done_out <= 1'b0;
			rel_q <= 1'b0;
		end else begin
			done_out <= 1'b0;
			case (st_q)
				H_IDLE: begin
					if (start_in) begin
						cs_q <= 1'b0;
						tx_q <= op_in;
						rel_q <= (op_in == RELEASE_SIGNATURE_OP);
						total_q <= (op_in == RELEASE_SIGNATURE_OP) ?
							8'(SIG_START_BIT) + {1'b0, sig_reads_in, 3'h0} :
							8'h8;
						nbits_q <= 8'h0;
						div_q <= 4'h0;
						st_q <= H_SHIFT;
					end
				end
				H_SHIFT: begin
					if (div_q == SCK_HALF - 4'h1) begin
						div_q <= 4'h0;
						if (!sck_q) begin
							sck_q <= 1'b1;
							nbits_q <= nbits_q + 8'h1;
						end else begin
							// so taken at end of high phase: sync lag on
							// both ends is longer than half a period
							sck_q <= 1'b0;
							rx_q <= {rx_q[6:0], so_s_q[1]};
							tx_q <= {tx_q[6:0], 1'b0};
							if (nbits_q == total_q) begin
								cs_q <= 1'b1;
								sig_out <= {rx_q[6:0], so_s_q[1]};
								wait_q <= rel_q ? 17'(RELEASE_CYC) + 17'h2 :
									17'(PROTECT_CYC) + 17'h2;
								st_q <= H_GAP;
							end
						end
					end else begin
						div_q <= div_q + 4'h1;
					end
				end
				H_GAP: begin
					if (wait_q == 17'h0) begin
						st_q <= H_IDLE;
						done_out <= 1'b1;
					end else begin
						wait_q <= wait_q - 17'h1;
					end
				end
				default: begin
					st_q <= H_IDLE;
				end
			endcase
		end
	end
	assign link.chip_select_n = cs_q;
	assign link.sck = sck_q;
	assign link.si = tx_q[7];
	assign busy_out = (st_q != H_IDLE);
endmodule

// ---- tb/sig_link_asserts.sv ----
// Purpose: wire checks on the host to device link
// Assumes: spi mode 0, sck made from clk_in
// Notes: sck rises are counted per frame
`timescale 1ns/1ps
module sig_link_asserts
	import sig_pkg::*;
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic chip_select_n,
	input wire logic sck,
	input wire logic si,
	input wire logic so_o,
	input wire logic so_oe_n,
	input wire logic so
);
	logic sck_q; // sck one cycle ago
	logic [7:0] rise_q; // sck rises in this frame
	logic [7:0] high_q; // deselected cycles, saturating
	logic [15:0] up_q; // cycles since reset, saturating
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// sck history for edge finding
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) sck_q <= 1'b0;
		else sck_q <= sck;
	end
	// rise count, cleared while deselected
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) rise_q <= 8'h00;
		else if (chip_select_n) rise_q <= 8'h00;
		else if (sck && !sck_q) rise_q <= rise_q + 8'h01;
	end
	// deselect and power-up timers
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			high_q <= 8'h00;
			up_q <= 16'h0000;
		end else begin
			if (!chip_select_n) high_q <= 8'h00;
			else if (high_q != 8'hFF) high_q <= high_q + 8'h01;
			if (up_q != 16'hFFFF) up_q <= up_q + 16'h0001;
		end
	end
	sequence s_hold;
		$stable(so_o) [*3];
	endsequence
	a_cs_rise_clean: assert property ($rose(chip_select_n) |->
		!sck && rise_q[2:0] == 3'h0) else $error("cs rose mid byte");
	a_so_released: assert property (chip_select_n [*5] |-> so_oe_n)
		else $error("so driven while deselected");
	a_dummy_quiet: assert property (!chip_select_n &&
		rise_q < 8'h20 |-> so_oe_n) else $error("so driven early");
	a_sig_bits: assert property ($rose(sck) && !so_oe_n &&
		rise_q >= 8'h20 |-> so == SIGNATURE_VAL[3'h7 - rise_q[2:0]])
		else $error("signature bit wrong");
	a_so_change_low: assert property ($changed(so_o) &&
		!so_oe_n |-> !sck) else $error("so moved while sck high");
	a_so_hold_high: assert property ($rose(sck) &&
		!so_oe_n |=> s_hold) else $error("so unstable in sck high");
	a_gap_held: assert property ($fell(chip_select_n) |->
		high_q >= RELEASE_CYC) else $error("deselect gap short");
	a_powerup_wait: assert property ($fell(chip_select_n) |->
		up_q >= POWERUP_CYC) else $error("selected before power-up");
endmodule

// ---- tb/spi_flash_release_signature_powerup_test.sv ----
// Purpose: host and device run end to end over the link
// Assumes: package delays as shipped, power-up 50000 cycles
// Notes: device flags or signature judged after each host frame
`timescale 1ns/1ps
module spi_flash_release_signature_powerup_test
	import sig_pkg::*;
;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic busy_in = 1'b0;
	logic wel_set_in = 1'b0;
	logic start_in = 1'b0;
	logic [7:0] op_in = 8'h00;
	logic [3:0] sig_reads_in = 4'h0;
	logic busy_flag_out, write_enable_latch_out;
	logic soft_protect_mode_out, ready_out;
	logic busy_out, done_out;
	logic [7:0] sig_out;
	int mismatches = 0;
	int cmp_count = 0;
	spi_link_if spi_link_if_inst();
	// system clock
	always #20 clk_in = ~clk_in;
	sig_device sig_device_inst (.clk_in(clk_in), .rstn_in(rstn_in),
		.link(spi_link_if_inst), .busy_in(busy_in),
		.wel_set_in(wel_set_in), .busy_flag_out(busy_flag_out),
		.write_enable_latch_out(write_enable_latch_out),
		.soft_protect_mode_out(soft_protect_mode_out),
		.ready_out(ready_out));
	sig_host sig_host_inst (.clk_in(clk_in), .rstn_in(rstn_in),
		.link(spi_link_if_inst), .start_in(start_in), .op_in(op_in),
		.sig_reads_in(sig_reads_in), .busy_out(busy_out),
		.done_out(done_out), .sig_out(sig_out));
	sig_link_asserts sig_link_asserts_inst (.clk_in(clk_in),
		.rstn_in(rstn_in), .chip_select_n(spi_link_if_inst.chip_select_n),
		.sck(spi_link_if_inst.sck), .si(spi_link_if_inst.si),
		.so_o(spi_link_if_inst.so_o), .so_oe_n(spi_link_if_inst.so_oe_n),
		.so(spi_link_if_inst.so));
	// compare and count
	task automatic chk(input string name, input logic [7:0] exp,
		input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	// wait for the host done pulse, bounded
	task automatic wait_done(input int lim);
		int i;
		for (i = 0; i < lim && done_out !== 1'b1; i++) @(negedge clk_in);
		chk("done", 8'h01, {7'h00, done_out});
	endtask
	// one host frame: opcode and signature byte count
	task automatic send(input logic [7:0] op, input logic [3:0] n);
		@(posedge clk_in);
		op_in <= op;
		sig_reads_in <= n;
		start_in <= 1'b1;
		@(posedge clk_in);
		start_in <= 1'b0;
		wait_done(3000);
		repeat (8) @(negedge clk_in);
	endtask
	// one write enable pulse
	task automatic pulse_wel();
		@(posedge clk_in);
		wel_set_in <= 1'b1;
		@(posedge clk_in);
		wel_set_in <= 1'b0;
		repeat (3) @(negedge clk_in);
	endtask
	// reset state, then the power-up lockout
	task automatic t_powerup();
		chk("so_oe_n", 8'h01, {7'h00, spi_link_if_inst.so_oe_n});
		@(posedge clk_in);
		rstn_in <= 1'b1;
		@(negedge clk_in);
		chk("ready", 8'h00, {7'h00, ready_out});
		chk("protect", 8'h00, {7'h00, soft_protect_mode_out});
		chk("wel", 8'h00, {7'h00, write_enable_latch_out});
		wait_done(50200);
		chk("ready", 8'h01, {7'h00, ready_out});
	endtask
	// long read: signature repeats
	task automatic t_sig();
		send(RELEASE_SIGNATURE_OP, 4'hF);
		chk("sig", SIGNATURE_VAL, sig_out);
	endtask
	// one protect opcode, refused write, release
	task automatic t_protect(input logic [7:0] op, input logic [3:0] n);
		send(op, 4'h0);
		chk("protect", 8'h01, {7'h00, soft_protect_mode_out});
		pulse_wel();
		chk("wel", 8'h00, {7'h00, write_enable_latch_out});
		send(RELEASE_SIGNATURE_OP, n);
		if (n != 4'h0) chk("sig", SIGNATURE_VAL, sig_out);
		chk("protect", 8'h00, {7'h00, soft_protect_mode_out});
	endtask
	// release while a self-timed cycle runs
	task automatic t_busy();
		pulse_wel();
		chk("wel", 8'h01, {7'h00, write_enable_latch_out});
		@(posedge clk_in);
		busy_in <= 1'b1;
		repeat (3) @(negedge clk_in);
		chk("busy", 8'h01, {7'h00, busy_flag_out});
		send(RELEASE_SIGNATURE_OP, 4'h1);
		chk("sig", 8'hFF, sig_out);
		chk("wel", 8'h01, {7'h00, write_enable_latch_out});
		@(posedge clk_in);
		busy_in <= 1'b0;
		repeat (3) @(negedge clk_in);
		chk("busy", 8'h00, {7'h00, busy_flag_out});
		chk("wel", 8'h00, {7'h00, write_enable_latch_out});
	endtask
	// verdict and stop
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (70000) @(posedge clk_in);
		mismatches++;
		end_of_test();
	end
	// main sequence
	initial begin
		repeat (8) @(negedge clk_in);
		t_powerup();
		t_sig();
		t_protect(SOFT_PROTECT_OP, 4'h1);
		t_protect(DEEP_POWERDOWN_OP, 4'h0);
		t_busy();
		end_of_test();
	end
endmodule
